// file: rtl/adc_chan_defs.vh
`ifndef ADC_CHAN_DEFS_VH
`define ADC_CHAN_DEFS_VH

// register indices (byte address is four times the index)
`define IDX_CCR_FIRST 10'h020
`define IDX_CCR_LAST 10'h03E
`define IDX_BND_FIRST 10'h084
`define IDX_BND_LAST 10'h08A
`define IDX_FLAGS 10'h090
`define IDX_FLAG_CLR 10'h092
`define IDX_NPTR_FIRST 10'h098
`define IDX_NPTR_LAST 10'h09E
`define IDX_ALIAS 10'h0A0
`define IDX_ICLS_FIRST 10'h0C0
`define IDX_ICLS_LAST 10'h0C2

// channel control fields
`define CCR_BNDA 1:0
`define CCR_BNDB 3:2
`define CCR_LCC 6:4
`define CCR_SYNC 7
`define CCR_REF 9:8
`define CCR_ICL 10
`define CCR_ICLF 11:10
`define CCR_RESR 14:12
`define CCR_MASK 16'h7FFF
`define CCR_RST 16'h0000

// input class fields
`define ICLS_STC 7:0
`define ICLS_DW 9:8
`define ICLS_MASK 16'h03FF
`define ICLS_RST 16'h0000
`define MIN_SAMPLE 9'h002

// boundaries, twelve-bit representation, bits 11:2 kept
`define BND_MASK 12'hFFC
`define BND0_RST 12'h198
`define BND1_RST 12'hE64
`define BND2_RST 12'h554
`define BND3_RST 12'hAA8

// node pointer layout and alias register
`define NPTR_MASK 16'h3333
`define ALIAS0 3:0
`define ALIAS1 11:8
`define ALIAS_MASK 16'h0F0F
`define ALIAS_RST 16'h0100
`define REF_ALT 2'h1

// bus answers
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// file: rtl/adc_channel_ctrl.v
// Summary of operation
// - apply selected channel settings to each conversion
// - two input classes share sample length, resolution
// - default class: two sample cycles, ten bits
// - per channel standard or channel-zero reference
// - redirect only requests for channels zero, one
// - redirected request keeps the requested channel's settings
// - compare result with two of four boundaries
// - areas one, two, three from both comparisons
// - limit check code selects event condition
// - equal boundaries leave area two empty
// - channel event sets its flag
// - software one sets flag, zero ignored
// - one in clear register clears flag
// - pulse selected service line on event, set
// - per-channel bit requests synchronized conversion when syncMaster is set
// - sample phase is two plus extension cycles
// - boundary reset values 10, 90, 33, 66 percent
// - clear wins over simultaneous event
// - node pointer picks service line zero to three
//
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
`include "adc_chan_defs.vh"
module adc_channel_ctrl #(
    parameter NCH = 16, // channel count
    parameter NSR = 4 // service request lines
) (
    input wire clk, // module clock
    input wire rst_n, // synchronous reset, low active
    input wire [11:0] s_axi_awaddr, // write address
    input wire s_axi_awvalid, // write address valid
    output reg s_axi_awready, // write address ready
    input wire [31:0] s_axi_wdata, // write data
    input wire [3:0] s_axi_wstrb, // write byte strobes
    input wire s_axi_wvalid, // write data valid
    output reg s_axi_wready, // write data ready
    output reg [1:0] s_axi_bresp, // write response
    output reg s_axi_bvalid, // write response valid
    input wire s_axi_bready, // write response ready
    input wire [11:0] s_axi_araddr, // read address
    input wire s_axi_arvalid, // read address valid
    output reg s_axi_arready, // read address ready
    output reg [31:0] s_axi_rdata, // read data
    output reg [1:0] s_axi_rresp, // read response
    output reg s_axi_rvalid, // read data valid
    input wire s_axi_rready, // read data ready
    input wire convReq, // arbiter picked a channel, one cycle
    input wire [3:0] convChan, // channel picked by arbiter
    input wire syncMaster, // kernel may act as sync master
    output reg convStart, // settings valid, one cycle
    output reg [3:0] convInput, // analog input to sample
    output reg [8:0] convSample, // sample phase in analog clocks
    output reg [1:0] convWidth, // data width code
    output reg convRefAlt, // use channel zero as reference
    output reg convSync, // synchronized conversion request
    output reg [2:0] convResReg, // target result register
    input wire resultValid, // result ready, one cycle
    input wire [11:0] resultData, // result, twelve-bit aligned
    output reg [NSR-1:0] srOut // service request pulses
);
    reg [15:0] ccr_r [0:NCH-1]; // channel control array
    reg [15:0] icls_r [0:1]; // input class settings
    reg [11:0] bnd_r [0:3]; // boundary values
    reg [2*NCH-1:0] nptr_r; // node pointers, two bits each
    reg [15:0] alias_r; // alias targets for channels zero, one
    reg [NCH-1:0] flags_r; // channel event flags
    reg [NCH-1:0] flags_nxt; // next flags
    reg [3:0] resChan_r; // channel of conversion under way
    reg [NSR-1:0] sr_nxt; // next service request pulses
    reg [NCH-1:0] evtVec; // one-hot channel event
    reg [NCH-1:0] swSet; // software set vector
    reg [NCH-1:0] swClr; // software clear vector
    reg [31:0] rd_nxt; // read data of addressed register
    reg rdOk; // read address is mapped
    reg [15:0] selCcr; // settings of picked channel
    reg [15:0] selCls; // class of picked channel
    reg [3:0] aliasIn; // analog input after redirection
    wire wrFire; // write address and data taken
    wire rdFire; // read address taken
    wire [9:0] wIdx; // write register index
    wire [9:0] rIdx; // read register index
    wire [15:0] wMask; // byte lanes as bit mask
    wire [15:0] wVal; // strobed write value
    wire [15:0] resCcr; // settings of resulting channel
    wire [15:0] bndWr; // merged boundary write, trimmed to bits 11:2
    wire chanEvt; // limit check says event
    integer i; // loop index, write process
    integer j; // loop index, read multiplexer
    integer k; // loop index, flag routing

    // true when idx is an even index within first..last
    function inRange;
        input [9:0] idx;
        input [9:0] first;
        input [9:0] last;
        begin
            inRange = (idx >= first) && (idx <= last) && !idx[0];
        end
    endfunction

    // merge strobed bytes of a new value into an old one
    function [15:0] merge;
        input [15:0] old;
        input [15:0] nw;
        input [15:0] msk;
        input [15:0] keep;
        begin
            merge = ((old & ~msk) | (nw & msk)) & keep;
        end
    endfunction

    // boundary slot of an index; the first boundary index is slot zero
    function [1:0] bndSlot;
        input [9:0] idx;
        begin
            bndSlot = idx[2:1] ^ 2'h2;
        end
    endfunction

    // any index that answers OKAY
    function mapped;
        input [9:0] idx;
        begin
            mapped = inRange(idx, `IDX_CCR_FIRST, `IDX_CCR_LAST) ||
                inRange(idx, `IDX_BND_FIRST, `IDX_BND_LAST) ||
                inRange(idx, `IDX_NPTR_FIRST, `IDX_NPTR_LAST) ||
                inRange(idx, `IDX_ICLS_FIRST, `IDX_ICLS_LAST) ||
                idx == `IDX_FLAGS || idx == `IDX_FLAG_CLR ||
                idx == `IDX_ALIAS;
        end
    endfunction

    assign wrFire = s_axi_awready && s_axi_awvalid && s_axi_wvalid;
    assign rdFire = s_axi_arready && s_axi_arvalid;
    assign wIdx = s_axi_awaddr[11:2];
    assign rIdx = s_axi_araddr[11:2];
    assign wMask = {{8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
    assign wVal = s_axi_wdata[15:0] & wMask;
    assign resCcr = ccr_r[resChan_r];
    // boundary fields hold twelve bits; bits 15:12 and 1:0 are dropped below
    assign bndWr = merge({4'h0, bnd_r[bndSlot(wIdx)]}, s_axi_wdata[15:0],
        wMask, {4'h0, `BND_MASK});

    // result of the running conversion against its channel limits
    limit_check u_limit (
        .result(resultData),
        .bndA(bnd_r[resCcr[`CCR_BNDA]]),
        .bndB(bnd_r[resCcr[`CCR_BNDB]]),
        .limit_check_control(resCcr[`CCR_LCC]),
        .evt(chanEvt)
    );

    // flag set, clear and service line routing
    always @* begin
        evtVec = {NCH{1'b0}};
        swSet = {NCH{1'b0}};
        swClr = {NCH{1'b0}};
        sr_nxt = {NSR{1'b0}};
        if (resultValid && chanEvt) begin
            evtVec[resChan_r] = 1'b1;
        end
        if (wrFire && wIdx == `IDX_FLAGS) begin
            swSet = wVal;
        end
        if (wrFire && wIdx == `IDX_FLAG_CLR) begin
            swClr = wVal;
        end
        flags_nxt = (flags_r | evtVec | swSet) & ~swClr;
        for (k = 0; k < NCH; k = k + 1) begin
            if (evtVec[k] || swSet[k]) begin
                sr_nxt[nptr_r[2*k +: 2]] = 1'b1;
            end
        end
    end

    // settings of the picked channel, with alias redirection
    always @* begin
        selCcr = ccr_r[convChan];
        selCls = icls_r[selCcr[`CCR_ICL]];
        case (convChan)
            4'h0: aliasIn = alias_r[`ALIAS0];
            4'h1: aliasIn = alias_r[`ALIAS1];
            default: aliasIn = convChan;
        endcase
    end

    // read multiplexer over the register map
    always @* begin
        rd_nxt = 32'h00000000;
        rdOk = mapped(rIdx);
        if (inRange(rIdx, `IDX_CCR_FIRST, `IDX_CCR_LAST)) begin
            rd_nxt[15:0] = ccr_r[rIdx[4:1]];
        end else if (inRange(rIdx, `IDX_BND_FIRST, `IDX_BND_LAST)) begin
            rd_nxt[11:0] = bnd_r[bndSlot(rIdx)];
        end else if (inRange(rIdx, `IDX_NPTR_FIRST, `IDX_NPTR_LAST)) begin
            for (j = 0; j < 4; j = j + 1) begin
                rd_nxt[4*j +: 2] = nptr_r[8*rIdx[2:1] + 2*j +: 2];
            end
        end else if (inRange(rIdx, `IDX_ICLS_FIRST, `IDX_ICLS_LAST)) begin
            rd_nxt[15:0] = icls_r[rIdx[1]];
        end else if (rIdx == `IDX_FLAGS) begin
            rd_nxt[NCH-1:0] = flags_r;
        end else if (rIdx == `IDX_ALIAS) begin
            rd_nxt[15:0] = alias_r;
        end
    end

    // write channel handshake and register updates
    always @(posedge clk) begin
        if (!rst_n) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
            for (i = 0; i < NCH; i = i + 1) begin
                ccr_r[i] <= `CCR_RST;
            end
            icls_r[0] <= `ICLS_RST;
            icls_r[1] <= `ICLS_RST;
            bnd_r[0] <= `BND0_RST;
            bnd_r[1] <= `BND1_RST;
            bnd_r[2] <= `BND2_RST;
            bnd_r[3] <= `BND3_RST;
            nptr_r <= {2*NCH{1'b0}};
            alias_r <= `ALIAS_RST;
            flags_r <= {NCH{1'b0}};
        end else begin
            flags_r <= flags_nxt;
            if (wrFire) begin
                // ready drops once both items are taken
                s_axi_awready <= 1'b0;
                s_axi_wready <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= mapped(wIdx) ? `RESP_OKAY : `RESP_SLVERR;
            end else if (s_axi_awvalid && s_axi_wvalid &&
                    !s_axi_awready && !s_axi_bvalid) begin
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (wrFire) begin
                if (inRange(wIdx, `IDX_CCR_FIRST, `IDX_CCR_LAST)) begin
                    ccr_r[wIdx[4:1]] <= merge(ccr_r[wIdx[4:1]],
                        s_axi_wdata[15:0], wMask, `CCR_MASK);
                end
                if (inRange(wIdx, `IDX_ICLS_FIRST, `IDX_ICLS_LAST)) begin
                    icls_r[wIdx[1]] <= merge(icls_r[wIdx[1]],
                        s_axi_wdata[15:0], wMask, `ICLS_MASK);
                end
                if (inRange(wIdx, `IDX_BND_FIRST, `IDX_BND_LAST)) begin
                    bnd_r[bndSlot(wIdx)] <= bndWr[11:0];
                end
                if (inRange(wIdx, `IDX_NPTR_FIRST, `IDX_NPTR_LAST)) begin
                    for (i = 0; i < 4; i = i + 1) begin
                        if (s_axi_wstrb[i/2]) begin
                            nptr_r[8*wIdx[2:1] + 2*i +: 2] <=
                                s_axi_wdata[4*i +: 2];
                        end
                    end
                end
                if (wIdx == `IDX_ALIAS) begin
                    alias_r <= merge(alias_r, s_axi_wdata[15:0], wMask,
                        `ALIAS_MASK);
                end
            end
        end
    end

    // read channel: address taken, data one cycle later
    always @(posedge clk) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `RESP_OKAY;
        end else begin
            if (rdFire) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_nxt;
                s_axi_rresp <= rdOk ? `RESP_OKAY : `RESP_SLVERR;
            end else if (s_axi_arvalid && !s_axi_arready &&
                    !s_axi_rvalid) begin
                s_axi_arready <= 1'b1;
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // hands picked channel's settings to the converter
    always @(posedge clk) begin
        if (!rst_n) begin
            convStart <= 1'b0;
            convInput <= 4'h0;
            convSample <= `MIN_SAMPLE;
            convWidth <= 2'h0;
            convRefAlt <= 1'b0;
            convSync <= 1'b0;
            convResReg <= 3'h0;
            resChan_r <= 4'h0;
            srOut <= {NSR{1'b0}};
        end else begin
            srOut <= sr_nxt;
            convStart <= convReq;
            if (convReq) begin
                resChan_r <= convChan;
                convInput <= aliasIn;
                convSample <= `MIN_SAMPLE +
                    {1'b0, selCls[`ICLS_STC]};
                convWidth <= selCls[`ICLS_DW];
                convRefAlt <= selCcr[`CCR_REF] == `REF_ALT;
                convSync <= selCcr[`CCR_SYNC] && syncMaster;
                convResReg <= selCcr[`CCR_RESR];
            end
        end
    end
endmodule

// file: rtl/limit_check.v
`timescale 1ns/1ps
// sorts a twelve-bit result into areas and decides on a channel event
module limit_check (
    input wire [11:0] result, // conversion result, twelve-bit aligned
    input wire [11:0] bndA, // boundary a
    input wire [11:0] bndB, // boundary b
    input wire [2:0] limit_check_control, // limit check control code
    output reg evt // channel event condition
);
    reg aboveA; // result strictly above a
    reg aboveB; // result strictly above b
    reg inI; // area one
    reg inII; // area two
    reg inIII; // area three

    // equal boundaries make area two empty by construction
    always @* begin
        aboveA = result > bndA;
        aboveB = result > bndB;
        inI = !aboveA && !aboveB;
        inIII = aboveA && aboveB;
        inII = aboveA ^ aboveB;
        case (limit_check_control)
            3'h0: evt = 1'b0;
            3'h1: evt = !inI;
            3'h2: evt = !inII;
            3'h3: evt = !inIII;
            3'h4: evt = 1'b1;
            3'h5: evt = inI;
            3'h6: evt = inII;
            3'h7: evt = inIII;
            default: evt = 1'b0;
        endcase
    end
endmodule

// file: test/adc_channel_ctrl_props.sv
`timescale 1ns/1ps
// bus handshake and conversion/event checks on the top ports
module adc_channel_ctrl_props #(
    parameter NSR = 4 // service lines
) (
    input wire clk, // clock
    input wire rst_n, // reset
    input wire s_axi_awvalid, // aw valid
    input wire s_axi_awready, // aw ready
    input wire s_axi_wvalid, // w valid
    input wire s_axi_bvalid, // b valid
    input wire s_axi_bready, // b ready
    input wire [1:0] s_axi_bresp, // b resp
    input wire s_axi_arvalid, // ar valid
    input wire s_axi_arready, // ar ready
    input wire s_axi_rvalid, // r valid
    input wire convReq, // request
    input wire [3:0] convChan, // channel
    input wire syncMaster, // sync allowed
    input wire convStart, // start
    input wire [3:0] convInput, // input
    input wire [8:0] convSample, // sample
    input wire convSync, // sync
    input wire resultValid, // result
    input wire [NSR-1:0] srOut // service
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    a_start_next: assert property (convReq |=> convStart)
        else $error("no start after request");
    a_start_cause: assert property (convStart |-> $past(convReq))
        else $error("start without request");
    a_sample_min: assert property (convStart |-> convSample >= 9'h002)
        else $error("sample phase too short");
    a_plain_input: assert property (
        convReq && convChan > 4'h1 |=> convInput == $past(convChan))
        else $error("input redirected");
    a_sync_gate: assert property (convReq && !syncMaster |=> !convSync)
        else $error("sync without master");
    a_sr_cause: assert property (|srOut |->
        $past(resultValid || (s_axi_awready && s_axi_awvalid)))
        else $error("service pulse without cause");
    a_write_resp: assert property (
        s_axi_awready && s_axi_awvalid |=> s_axi_bvalid)
        else $error("write response late");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_read_resp: assert property (
        s_axi_arready && s_axi_arvalid |=> s_axi_rvalid)
        else $error("read response late");
    c_event: cover property (|srOut);
    c_sync: cover property (convStart && convSync);
    c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule

bind adc_channel_ctrl adc_channel_ctrl_props #(.NSR(NSR)) i_props (
    .clk(clk), .rst_n(rst_n), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
    .convReq(convReq), .convChan(convChan), .syncMaster(syncMaster),
    .convStart(convStart), .convInput(convInput),
    .convSample(convSample), .convSync(convSync),
    .resultValid(resultValid), .srOut(srOut));

// file: test/conv_partner.sv
`timescale 1ns/1ps
// arbiter and converter stand-in: one request, then one result
module conv_partner (
    input wire clk, // clock
    output reg convReq, // request pulse
    output reg [3:0] convChan, // channel
    output reg resultValid, // result pulse
    output reg [11:0] resultData // result
);
    initial begin
        convReq = 1'b0;
        convChan = 4'hF;
        resultValid = 1'b0;
        resultData = 12'hFFF;
    end
    // released lines show the inverse, never the old value
    task convert(input [3:0] ch, input [11:0] res);
        begin
            @(posedge clk);
            convReq <= 1'b1;
            convChan <= ch;
            @(posedge clk);
            convReq <= 1'b0;
            convChan <= ~ch;
            @(posedge clk);
            resultValid <= 1'b1;
            resultData <= res;
            @(posedge clk);
            resultValid <= 1'b0;
            resultData <= ~res;
        end
    endtask
endmodule

// file: test/test_adc_channel_limit_check_events.sv
`timescale 1ns/1ps
`include "adc_chan_defs.vh"
`define CHK(nm, ex, got) begin \
    compares = compares + 1; \
    if ((got) !== (ex)) begin \
        error_cnt = error_cnt + 1; \
        $display("unexpected %s exp %h got %h", nm, ex, got); \
    end \
end
module test_adc_channel_limit_check_events;
    localparam [11:0] CCR = {`IDX_CCR_FIRST, 2'b00}; // channel controls
    localparam [11:0] FLG = {`IDX_FLAGS, 2'b00}; // flags
    localparam [11:0] CLR = {`IDX_FLAG_CLR, 2'b00}; // flag clear
    localparam [11:0] NPT = {`IDX_NPTR_FIRST, 2'b00}; // node pointers
    localparam [47:0] BRST = {`BND3_RST, `BND2_RST, `BND1_RST, `BND0_RST};
    localparam [35:0] RES = {12'hE65, 12'hE64, 12'h198}; // areas 3..1
    reg clk = 1'b0, rst_n = 1'b0, syncMaster = 1'b0;
    reg s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    reg s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, ev;
    reg [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    reg [31:0] s_axi_wdata = 32'h00000000, rdVal;
    reg [3:0] s_axi_wstrb = 4'h3, srSeen = 4'h0;
    reg [1:0] rsp;
    integer error_cnt = 0, compares = 0, cycles = 0, i, limit_check_control, a;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    wire s_axi_rvalid, convReq, convStart, convRefAlt, convSync;
    wire resultValid;
    wire [1:0] s_axi_bresp, s_axi_rresp, convWidth;
    wire [31:0] s_axi_rdata;
    wire [3:0] convChan, convInput, srOut;
    wire [8:0] convSample;
    wire [2:0] convResReg;
    wire [11:0] resultData;

    adc_channel_ctrl i_dut (
        .clk(clk), .rst_n(rst_n), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .convReq(convReq), .convChan(convChan), .syncMaster(syncMaster),
        .convStart(convStart), .convInput(convInput),
        .convSample(convSample), .convWidth(convWidth),
        .convRefAlt(convRefAlt), .convSync(convSync),
        .convResReg(convResReg), .resultValid(resultValid),
        .resultData(resultData), .srOut(srOut));
    conv_partner i_partner (.clk(clk), .convReq(convReq),
        .convChan(convChan), .resultValid(resultValid),
        .resultData(resultData));

    always #25 clk = ~clk;
    // collect service pulses away from the sampling edge
    always @(negedge clk) srSeen <= srSeen | srOut;
    // hang guard
    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            error_cnt = error_cnt + 1;
            test_done;
        end
    end

    task test_done;
        begin
            if (error_cnt == 0 && compares > 0) $display("RESULT: PASS");
            else $display("RESULT: FAIL");
            $finish;
        end
    endtask
    // one register write, response kept in rsp
    task wr(input [11:0] ad, input [15:0] d);
        begin
            @(posedge clk);
            s_axi_awaddr <= ad;
            s_axi_wdata <= {16'h0000, d};
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
            s_axi_bready <= 1'b1;
            do @(posedge clk); while (!s_axi_awready);
            s_axi_awvalid <= 1'b0;
            s_axi_wvalid <= 1'b0;
            do @(posedge clk); while (!s_axi_bvalid);
            rsp = s_axi_bresp;
            s_axi_bready <= 1'b0;
        end
    endtask
    // one register read into rdVal
    task rd(input [11:0] ad);
        begin
            @(posedge clk);
            s_axi_araddr <= ad;
            s_axi_arvalid <= 1'b1;
            s_axi_rready <= 1'b1;
            do @(posedge clk); while (!s_axi_arready);
            s_axi_arvalid <= 1'b0;
            do @(posedge clk); while (!s_axi_rvalid);
            rdVal = s_axi_rdata;
            rsp = s_axi_rresp;
            s_axi_rready <= 1'b0;
        end
    endtask

    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        for (i = 0; i < 4; i = i + 1) begin
            rd({`IDX_BND_FIRST, 2'b00} + 12'(8 * i));
            `CHK("bound", {20'h00000, BRST[12*i +: 12]}, rdVal)
        end
        rd({`IDX_ALIAS, 2'b00});
        `CHK("alias", {16'h0000, `ALIAS_RST}, rdVal)
        rd(12'hFFC);
        `CHK("rresp", `RESP_SLVERR, rsp)
        wr(12'hFFC, 16'hFFFF);
        `CHK("bresp", `RESP_SLVERR, rsp)
        i_partner.convert(4'h5, 12'h000);
        `CHK("sample", 9'h002, convSample)
        `CHK("width", 2'h0, convWidth)
        wr({`IDX_ICLS_FIRST, 2'b00} + 12'h008, 16'h0205);
        wr(CCR + 12'h028, 16'h3580);
        wr(CCR + 12'h038, 16'h0480);
        syncMaster <= 1'b1;
        i_partner.convert(4'h5, 12'h000);
        `CHK("sample", 9'h007, convSample)
        `CHK("width", 2'h2, convWidth)
        `CHK("reference", 1'b1, convRefAlt)
        `CHK("sync", 1'b1, convSync)
        `CHK("result reg", 3'h3, convResReg)
        syncMaster <= 1'b0;
        i_partner.convert(4'h7, 12'h000);
        `CHK("sample", 9'h007, convSample)
        `CHK("reference", 1'b0, convRefAlt)
        `CHK("sync", 1'b0, convSync)
        wr({`IDX_ALIAS, 2'b00}, 16'h0109);
        wr(CCR, 16'h6000);
        i_partner.convert(4'h0, 12'h000);
        `CHK("input", 4'h9, convInput)
        `CHK("result reg", 3'h6, convResReg)
        wr(NPT, 16'h0200);
        // every limit check code against results on both boundaries and just above the upper one
        for (i = 0; i < 24; i = i + 1) begin
            limit_check_control = i / 3;
            a = i % 3 + 1;
            ev = limit_check_control == 4 || (limit_check_control > 0 && limit_check_control < 4 && a != limit_check_control) ||
                (limit_check_control > 4 && a == limit_check_control - 4);
            wr(CCR + 12'h010, 16'(limit_check_control * 16 + 4));
            wr(CLR, 16'h0004);
            srSeen = 4'h0;
            i_partner.convert(4'h2, RES[12*(a-1) +: 12]);
            rd(FLG);
            `CHK("flags", {29'h0, ev, 2'h0}, rdVal)
            `CHK("service", {1'b0, ev, 2'h0}, srSeen)
        end
        // same boundary selected twice
        for (i = 0; i < 2; i = i + 1) begin
            wr(CCR + 12'h010, 16'(16'h006A + i * 16));
            wr(CLR, 16'h0004);
            i_partner.convert(4'h2, 12'h600);
            rd(FLG);
            `CHK("flags", 32'(i * 4), rdVal)
        end
        wr(CLR, 16'hFFFF);
        wr(NPT + 12'h008, 16'h0003);
        srSeen = 4'h0;
        wr(FLG, 16'h8010);
        rd(FLG);
        `CHK("flags", 32'h00008010, rdVal)
        `CHK("service", 4'h9, srSeen)
        wr(FLG, 16'h0000);
        wr(CLR, 16'h0010);
        rd(FLG);
        `CHK("flags", 32'h00008000, rdVal)
        test_done;
    end
endmodule
